/* File: hw/dmabc_top.sv */
// Purpose: band control register of a two channel dma in short mode
// Assumes: classic Wishbone slave, 32-bit data, sync reset
// Notes:   full address mode ties each B half's request and clear gates to its A half
// Operation
// - bit 15 picks channel 1 mode, bit 14 channel 0; 1 means full
// - in short mode, halves 1A and 1B behave as independent channels
// - in short mode, halves 0A and 0B run with separate control
// - bits 11 to 8 hold one acknowledge clear bit per sub-channel
// - enabled with ack set, each transfer clears the source pending flag
// - enabled with ack set, the source raises no cpu request
// - enabled with ack clear, source stays pending and may request cpu
// - after reset mode and ack bits all read zero
// - with enable clear, activation is ignored and source goes to cpu
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dmabc_top
   import dmabc_pkg::*;
(
   input  wire logic               clk_i,        // system clock, 20 MHz
   input  wire logic               rst_i,        // sync reset, high
   input  wire logic               wb_cyc_i,     // wishbone cycle
   input  wire logic               wb_stb_i,     // wishbone strobe
   input  wire logic               wb_we_i,      // wishbone write
   input  wire logic [7:0]         wb_adr_i,     // byte address
   input  wire logic [3:0]         wb_sel_i,     // byte lanes
   input  wire logic [31:0]        wb_dat_i,     // write data
   output logic      [31:0]        wb_dat_o,     // read data
   output logic                    wb_ack_o,     // access done
   input  wire logic [NUM_SUB-1:0] src_pend_i,   // source pending levels
   input  wire logic [NUM_SUB-1:0] xfer_done_i,  // transfer executed
   output logic      [NUM_SUB-1:0] dma_req_o,    // activation to dma
   output logic      [NUM_SUB-1:0] cpu_req_o,    // source requests to cpu
   output logic      [NUM_SUB-1:0] clr_src_o,    // clear source pulses
   output logic      [NUM_SUB-1:0] end_irq_o,    // transfer end request
   output logic      [1:0]         full_mode_o,  // mode per channel
   output logic                    irq_o         // event interrupt
);
   import dmabc_pkg::*;

   // register storage
   dmabc_ctrl_t        band;
   dmabc_ctrl_t        next_band;

   // bus decode
   logic               req;
   logic               take;
   logic               wr;
   logic               rd;
   logic               hit_band;
   logic               hit_stat;
   logic               hit_mask;
   logic               hit_live;
   logic [31:0]        rd_mux;
   logic [15:0]        band_word;
   logic [15:0]        band_wmask;
   logic [15:0]        band_wdata;

   // per sub-channel wiring
   dmabc_sub_t         sub_ctl [NUM_SUB];
   dmabc_evt_t         sub_evt [NUM_SUB];
   logic [NUM_EVT-1:0] evt_vec;
   logic [NUM_EVT-1:0] irq_status;
   logic [NUM_EVT-1:0] irq_mask;
   logic [NUM_SUB-1:0] ack_bits;
   logic [NUM_SUB-1:0] te_bits;
   logic [NUM_SUB-1:0] tie_bits;

   // expand lane selects to a 16-bit write mask
   function automatic logic [15:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // address match on a word offset
   function automatic logic adr_hit(input logic [7:0] adr,
                                    input logic [7:0] ofs);
      adr_hit = (adr[7:2] == ofs[7:2]);
   endfunction

   // channel mode bit for a sub-channel index
   function automatic logic full_of(input dmabc_ctrl_t c,
                                    input int unsigned idx);
      if (idx >= SUB_A_OF_CH1) begin
         full_of = c.ch1_full_addr_select;
      end else begin
         full_of = c.ch0_full_addr_select;
      end
   endfunction

   // control used by a sub-channel: own bits in short mode,
   // the A half bits when the channel runs in full mode
   function automatic dmabc_sub_t sub_of(input dmabc_ctrl_t c,
                                         input int unsigned idx);
      int unsigned src;
      src = idx;
      if (full_of(c, idx) == MODE_FULL) begin
         src = (idx >= SUB_A_OF_CH1) ? SUB_A_OF_CH1 : SUB_A_OF_CH0;
      end
      sub_of.transfer_enable  = c.transfer_enable[src];
      sub_of.ack_clear_enable = c.ack_clear_enable[src];
   endfunction

   // one access per cycle, ack lasts one cycle
   assign req      = wb_cyc_i & wb_stb_i;
   assign take     = req & ~wb_ack_o;
   assign wr       = take & wb_we_i;
   assign rd       = take & ~wb_we_i;

   // register select
   assign hit_band = adr_hit(wb_adr_i, ADR_BAND);
   assign hit_stat = adr_hit(wb_adr_i, ADR_STAT);
   assign hit_mask = adr_hit(wb_adr_i, ADR_MASK);
   assign hit_live = adr_hit(wb_adr_i, ADR_LIVE);

   // band write merge under lane selects
   assign band_wmask = lane_mask(wb_sel_i);
   assign band_wdata = wb_dat_i[15:0];
   assign band_word  = band;

   // reserved bits never stored, so they read zero however written
   always_comb begin
      next_band = band;
      if (wr && hit_band) begin
         next_band = (band_word & ~band_wmask) | (band_wdata & band_wmask);
      end
      next_band.rsvd = 2'h0;
   end

   // read data select, unmapped offsets read zero
   always_comb begin
      rd_mux = DATA_ZERO;
      if (hit_band) begin
         rd_mux[15:0] = band_word;
      end else if (hit_stat) begin
         rd_mux[NUM_EVT-1:0] = irq_status;
      end else if (hit_mask) begin
         rd_mux[NUM_EVT-1:0] = irq_mask;
      end else if (hit_live) begin
         rd_mux[NUM_SUB-1:0] = cpu_req_o;
         rd_mux[2*NUM_SUB-1:NUM_SUB] = dma_req_o;
      end
   end

   // band control register, cleared by reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         band <= BAND_RST;
      end else begin
         band <= next_band;
      end
   end

   // bus answer, one cycle after the request is seen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= DATA_ZERO;
      end else begin
         wb_ack_o <= take;
         wb_dat_o <= rd ? rd_mux : DATA_ZERO;
      end
   end

   // field views for the sub-channels
   assign ack_bits = band.ack_clear_enable;
   assign te_bits  = band.transfer_enable;
   assign tie_bits = band.end_irq_enable;

   // transfer end request while end irq set and transfer disabled
   assign end_irq_o   = tie_bits & ~te_bits;
   assign full_mode_o = {band.ch1_full_addr_select, band.ch0_full_addr_select};

   // one gate per sub-channel, on its own controls in short mode, on the A half controls in full mode
   for (genvar g = 0; g < NUM_SUB; g++) begin : g_sub
      // short mode keeps the halves apart
      assign sub_ctl[g] = sub_of(band, g);

      dmabc_subch u_subch (
         .clk_i       (clk_i),
         .rst_i       (rst_i),
         .ctl_i       (sub_ctl[g]),
         .src_pend_i  (src_pend_i[g]),
         .xfer_done_i (xfer_done_i[g]),
         .dma_req_o   (dma_req_o[g]),
         .cpu_req_o   (cpu_req_o[g]),
         .clr_src_o   (clr_src_o[g]),
         .evt_o       (sub_evt[g])
      );

      // gather event pulses into status layout
      assign evt_vec[EVT_CLR_LSB+g]  = sub_evt[g].auto_cleared;
      assign evt_vec[EVT_LEFT_LSB+g] = sub_evt[g].left_pending;
   end

   // sticky events, read clear, masked interrupt
   dmabc_irq u_irq (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .evt_i     (evt_vec),
      .rd_clr_i  (rd & hit_stat),
      .mask_we_i (wr & hit_mask & wb_sel_i[0]),
      .mask_d_i  (wb_dat_i[NUM_EVT-1:0]),
      .status_o  (irq_status),
      .mask_o    (irq_mask),
      .irq_o     (irq_o)
   );

endmodule
`default_nettype wire

/* File: shared/dmabc_pkg.sv */
// Purpose: constants and types shared by the band control block
// Assumes: 20 MHz system clock, classic Wishbone with 32-bit data
// Notes:   sub-channel index 0=0A, 1=0B, 2=1A, 3=1B
package dmabc_pkg;

   // clock rate, for reference by the bench
   localparam int unsigned CLK_HZ       = 20000000;

   // register byte offsets
   localparam logic [7:0]  ADR_BAND     = 8'h00;
   localparam logic [7:0]  ADR_STAT     = 8'h04;
   localparam logic [7:0]  ADR_MASK     = 8'h08;
   localparam logic [7:0]  ADR_LIVE     = 8'h0C;

   // field positions inside the band control word
   localparam int unsigned CH1_FULL_BIT = 15;
   localparam int unsigned CH0_FULL_BIT = 14;
   localparam int unsigned RSVD_HI_BIT  = 13;
   localparam int unsigned RSVD_LO_BIT  = 12;
   localparam int unsigned ACK_LSB      = 8;
   localparam int unsigned TE_LSB       = 4;
   localparam int unsigned TIE_LSB      = 0;

   // field positions inside the event status word
   localparam int unsigned EVT_CLR_LSB  = 0;
   localparam int unsigned EVT_LEFT_LSB = 4;

   // sizes
   localparam int unsigned NUM_SUB      = 4;
   localparam int unsigned NUM_EVT      = 8;
   localparam int unsigned SUB_A_OF_CH0 = 0;
   localparam int unsigned SUB_A_OF_CH1 = 2;

   // reset values
   localparam logic [15:0] BAND_RST     = 16'h0000;
   localparam logic [7:0]  STAT_RST     = 8'h00;
   localparam logic [7:0]  MASK_RST     = 8'h00;
   localparam logic [31:0] DATA_ZERO    = 32'h00000000;

   // mode encoding of one full address select bit
   localparam logic        MODE_SHORT   = 1'b0;
   localparam logic        MODE_FULL    = 1'b1;

   // band control word as stored
   typedef struct packed {
      logic       ch1_full_addr_select;
      logic       ch0_full_addr_select;
      logic [1:0] rsvd;
      logic [3:0] ack_clear_enable;
      logic [3:0] transfer_enable;
      logic [3:0] end_irq_enable;
   } dmabc_ctrl_t;

   // controls that steer one sub-channel
   typedef struct packed {
      logic transfer_enable;
      logic ack_clear_enable;
   } dmabc_sub_t;

   // events reported by one sub-channel
   typedef struct packed {
      logic auto_cleared;
      logic left_pending;
   } dmabc_evt_t;

endpackage

/* File: hw/dmabc_subch.sv */
// Purpose: acknowledge gating of one sub-channel
// Assumes: source and transfer inputs come from logic on clk_i
// Notes:   clear strobe is registered, request paths are combinational
`timescale 1ns/10ps
`default_nettype none
module dmabc_subch
   import dmabc_pkg::*;
(
   input  wire logic         clk_i,        // system clock
   input  wire logic         rst_i,        // sync reset, high
   input  wire dmabc_sub_t   ctl_i,        // enable and ack control
   input  wire logic         src_pend_i,   // source pending level
   input  wire logic         xfer_done_i,  // one transfer executed
   output logic              dma_req_o,    // activation to dma
   output logic              cpu_req_o,    // source request to cpu
   output logic              clr_src_o,    // clear source pulse
   output dmabc_evt_t        evt_o         // event pulses
);
   import dmabc_pkg::*;

   logic take_clear;
   logic leave_pend;

   // activation seen only while enabled, else ignored
   assign dma_req_o  = ctl_i.transfer_enable & src_pend_i;
   // request to cpu blocked while auto clearing
   assign cpu_req_o  = src_pend_i &
                       ~(ctl_i.transfer_enable & ctl_i.ack_clear_enable);
   // decide fate of source at each transfer
   assign take_clear = xfer_done_i & ctl_i.transfer_enable
                       & ctl_i.ack_clear_enable;
   assign leave_pend = xfer_done_i & ctl_i.transfer_enable
                       & ~ctl_i.ack_clear_enable;

   // registered clear strobe and event pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clr_src_o <= 1'b0;
         evt_o     <= '0;
      end else begin
         clr_src_o <= take_clear;
         evt_o     <= '{auto_cleared: take_clear, left_pending: leave_pend};
      end
   end

endmodule
`default_nettype wire

/* File: hw/dmabc_irq.sv */
// Purpose: sticky event status, mask and one level interrupt
// Assumes: read clear strobe is a one-cycle pulse
// Notes:   a new event in the clearing cycle survives the clear
`timescale 1ns/10ps
`default_nettype none
module dmabc_irq
   import dmabc_pkg::*;
(
   input  wire logic               clk_i,     // system clock
   input  wire logic               rst_i,     // sync reset, high
   input  wire logic [NUM_EVT-1:0] evt_i,     // event pulses
   input  wire logic               rd_clr_i,  // status read taken
   input  wire logic               mask_we_i, // mask write strobe
   input  wire logic [NUM_EVT-1:0] mask_d_i,  // mask write data
   output logic      [NUM_EVT-1:0] status_o,  // sticky status
   output logic      [NUM_EVT-1:0] mask_o,    // interrupt mask
   output logic                    irq_o      // level interrupt
);
   import dmabc_pkg::*;

   logic [NUM_EVT-1:0] next_status;

   // set wins over the read clear
   assign next_status = (rd_clr_i ? STAT_RST : status_o) | evt_i;
   assign irq_o       = |(status_o & mask_o);

   // status and mask storage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_o <= STAT_RST;
         mask_o   <= MASK_RST;
      end else begin
         status_o <= next_status;
         if (mask_we_i) begin
            mask_o <= mask_d_i;
         end
      end
   end

endmodule
`default_nettype wire

/* File: testbench/dmabc_monitor.sv */
// Purpose: port-level checks of the band control block
// Assumes: one clock domain, sync reset high
// Notes:   attached to the top module by bind
`timescale 1ns/10ps
`default_nettype none
module dmabc_monitor
   import dmabc_pkg::*;
(
   input wire logic               clk_i,       // system clock
   input wire logic               rst_i,       // sync reset
   input wire logic               wb_cyc_i,    // cycle
   input wire logic               wb_stb_i,    // strobe
   input wire logic               wb_we_i,     // write
   input wire logic [7:0]         wb_adr_i,    // address
   input wire logic [31:0]        wb_dat_o,    // read data
   input wire logic               wb_ack_o,    // answer
   input wire logic [NUM_SUB-1:0] src_pend_i,  // source levels
   input wire logic [NUM_SUB-1:0] xfer_done_i, // transfers
   input wire logic [NUM_SUB-1:0] dma_req_o,   // activations
   input wire logic [NUM_SUB-1:0] cpu_req_o,   // cpu requests
   input wire logic [NUM_SUB-1:0] clr_src_o,   // clear pulses
   input wire logic [NUM_SUB-1:0] end_irq_o,   // end requests
   input wire logic [1:0]         full_mode_o, // mode bits
   input wire logic               irq_o        // event interrupt
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // sub-channels run on their own bits: A halves always, B halves in short mode
   logic [NUM_SUB-1:0] own_ctl;
   assign own_ctl = {~full_mode_o[1], 1'b1, ~full_mode_o[0], 1'b1};
   // request taken and band write answered
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_band_wr;
      wb_ack_o && $past(wb_we_i) && $past(wb_adr_i[7:2]) == ADR_BAND[7:2];
   endsequence
   // bus answer and idle data
   bus_ack_a: assert property (s_take |=> wb_ack_o) else $error("no ack after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == DATA_ZERO) else $error("data not idle");
   // request routing per sub-channel
   req_split_a: assert property ((cpu_req_o | dma_req_o) == src_pend_i)
      else $error("source request lost");
   clr_cause_a: assert property ((clr_src_o & ~$past(xfer_done_i)) == '0)
      else $error("clear without transfer");
   clr_mute_a: assert property ((clr_src_o & $past(cpu_req_o)) == '0)
      else $error("cleared source reached cpu");
   end_split_a: assert property ((end_irq_o & dma_req_o & own_ctl) == '0)
      else $error("end request while enabled");
   full_ch0_a: assert property (full_mode_o[0] && src_pend_i[1] == src_pend_i[0]
      |-> dma_req_o[1] == dma_req_o[0]) else $error("0B not following 0A in full mode");
   full_ch1_a: assert property (full_mode_o[1] && src_pend_i[3] == src_pend_i[2]
      |-> dma_req_o[3] == dma_req_o[2]) else $error("1B not following 1A in full mode");
   mode_hold_a: assert property (!$stable(full_mode_o) |-> s_band_wr)
      else $error("mode changed without write");
   rst_clean_a: assert property (disable iff (1'b0) $fell(rst_i) |-> !wb_ack_o && !irq_o
      && full_mode_o == 2'b00 && clr_src_o == '0 && end_irq_o == '0)
      else $error("outputs not clear after reset");
endmodule
bind dmabc_top dmabc_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .src_pend_i(src_pend_i), .xfer_done_i(xfer_done_i),
   .dma_req_o(dma_req_o), .cpu_req_o(cpu_req_o), .clr_src_o(clr_src_o),
   .end_irq_o(end_irq_o), .full_mode_o(full_mode_o), .irq_o(irq_o));
`default_nettype wire

/* File: testbench/dmabc_top_tb.sv */
// Purpose: self-checking bench for the band control block
// Assumes: classic Wishbone master, one idle cycle between accesses
// Notes:   read words are checked against a queue of expected values
`timescale 1ns/10ps
`default_nettype none
module dmabc_top_tb;
   import dmabc_pkg::*;
   logic        clk, rst, cyc, stb, we, ack, irq;
   logic [7:0]  adr, stat_m;
   logic [3:0]  sel, pend, xfer, dma, cpu, clr, eirq, en, ak;
   logic [31:0] wdat, rdat;
   logic [1:0]  fm;
   logic [15:0] b;
   logic [31:0] exp_q[$];
   int          err_total, n_compared;
   dmabc_top dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .src_pend_i(pend), .xfer_done_i(xfer), .dma_req_o(dma), .cpu_req_o(cpu),
      .clr_src_o(clr), .end_irq_o(eirq), .full_mode_o(fm), .irq_o(irq));
   // clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
      n_compared++;
      if (got !== want) begin
         err_total++;
         $display("mismatch at %0t: word %h want %h", $time, got, want);
      end
   endtask
   task automatic chk_pin(input logic [3:0] got, input logic [3:0] want);
      n_compared++;
      if (got !== want) begin
         err_total++;
         $display("mismatch at %0t: pins %b want %b", $time, got, want);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // one classic cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
      n = 0;
      do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 16);
      if (ack !== 1'b1) begin
         err_total++;
         $display("mismatch at %0t: no bus answer", $time);
         conclude();
      end
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h00000000);
   endtask
   // effective enable and ack, B follows A in full mode
   task automatic eff();
      en = b[7:4]; ak = b[11:8];
      if (b[14]) begin en[1] = en[0]; ak[1] = ak[0]; end
      if (b[15]) begin en[3] = en[2]; ak[3] = ak[2]; end
   endtask
   // one transfer pulse, clear strobe checked while it stands
   task automatic pulse(input logic [3:0] g);
      @(posedge clk);
      xfer <= g;
      @(posedge clk);
      xfer <= 4'h0;
      @(negedge clk);
      chk_pin(clr, g & en & ak);
      @(posedge clk);
      @(negedge clk);
   endtask
   // read data watcher
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0) begin
         if (exp_q.size() == 0) begin
            err_total++;
            $display("mismatch at %0t: unexpected read", $time);
         end else chk_word(rdat, exp_q.pop_front());
      end
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("mismatch at %0t: run too long", $time);
      conclude();
   end
   // main sequence
   initial begin
      rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
      wdat = 32'h0; pend = 4'h0; xfer = 4'h0; stat_m = 8'h00;
      err_total = 0; n_compared = 0;
      void'($urandom(31));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(ADR_BAND, 32'h0);
      rd(ADR_STAT, 32'h0);
      rd(ADR_MASK, 32'h0);
      bus(1'b1, ADR_BAND, 32'h0000FFFF);
      rd(ADR_BAND, 32'h0000CFFF);
      chk_pin({2'b00, fm}, 4'h3);
      bus(1'b1, 8'h10, 32'h0000FFFF);
      rd(8'h10, 32'h0);
      for (int i = 0; i < 24; i++) begin
         b = 16'($urandom()) & 16'hCFFF;
         bus(1'b1, ADR_BAND, {16'h0000, b});
         eff();
         @(posedge clk); pend <= 4'($urandom());
         @(negedge clk);
         chk_pin(dma, en & pend);
         chk_pin(cpu, pend & ~(en & ak));
         chk_pin(eirq, b[3:0] & ~b[7:4]);
         chk_pin({2'b00, fm}, {2'b00, b[15:14]});
         rd(ADR_LIVE, {24'h0, en & pend, pend & ~(en & ak)});
         pulse(4'hF);
         chk_pin(clr, 4'h0);
         @(posedge clk); pend <= pend & ~(en & ~ak);
         @(negedge clk); chk_pin(cpu & en & ~ak, 4'h0);
         stat_m = stat_m | {en & ~ak, en & ak};
      end
      rd(ADR_STAT, {24'h0, stat_m});
      rd(ADR_STAT, 32'h0);
      bus(1'b1, ADR_BAND, 32'h00000110);
      for (int m = 1; m >= 0; m--) begin
         bus(1'b1, ADR_MASK, 32'(m));
         @(posedge clk); xfer <= 4'h1;
         @(posedge clk); xfer <= 4'h0;
         @(negedge clk); chk_pin(clr, 4'h1);
         @(posedge clk);
         @(negedge clk); chk_pin({3'b000, irq}, 4'(m));
         rd(ADR_STAT, 32'h1);
         @(negedge clk); chk_pin({3'b000, irq}, 4'h0);
      end
      conclude();
   end
endmodule
`default_nettype wire
